// [pkg/exec_cfg.svh]
// constants for the bit, flag and transfer execution block
// assumes inclusion by bare name from the package and the logic files
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// flag register bit positions
`define FLAG_C 3'd0
`define FLAG_Z 3'd1
`define FLAG_N 3'd2
`define FLAG_V 3'd3
`define FLAG_S 3'd4
`define FLAG_H 3'd5
`define FLAG_T 3'd6
`define FLAG_I 3'd7

// reset values
`define FLAGS_RESET 8'h00
`define REG_RESET 8'h00
`define ADDR_RESET 16'h0000

// low register index of the first pointer pair; pairs follow two apart
`define PTR_BASE 5'h1a

`endif

// [pkg/exec_pkg.sv]
// types shared by the execution block and its shift unit
// assumes exec_cfg.svh is on the include path
package exec_pkg;
   `include "exec_cfg.svh"

   // operations accepted by the execution block
   typedef enum logic [3:0] {
      op_nop, op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right,
      op_swap, op_flag_set, op_flag_clear, op_bit_to_flag_store, op_flag_to_bit_load,
      op_move, op_word_copy, op_indirect_load, op_displaced_load, op_direct_load,
      op_indirect_write
   } op_t;

   // pointer pair select
   typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_t;

   // pointer handling of indirect forms
   typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec} mode_t;

   // one instruction as presented to the block
   typedef struct packed {
      op_t op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [2:0] bsel;
      ptr_t ptr;
      mode_t mode;
      logic [5:0] q;
      logic [15:0] k;
   } exec_req_t;

   // data memory access issued by the block
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } mem_req_t;
endpackage

// [logic/flag_shift_unit.sv]
// rotate and shift datapath with its flag results
// assumes a purely combinational use inside the execution block
`timescale 1ns/1ps
`default_nettype none
module flag_shift_unit
   import exec_pkg::*;
(
   input wire exec_pkg::op_t op,
   input wire logic [7:0] operand,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic c_out,
   output logic z_out,
   output logic n_out,
   output logic v_out
);
   // shifted value and carry out per operation
   always_comb begin
      result = operand;
      c_out = carry_in;
      unique case (op)
         op_rotate_left_carry: begin
            result = {operand[6:0], carry_in};
            c_out = operand[7];
         end
         op_rotate_right_carry: begin
            result = {carry_in, operand[7:1]};
            c_out = operand[0];
         end
         op_arith_shift_right: begin
            result = {operand[7], operand[7:1]};
            c_out = operand[0];
         end
         default: begin
         end
      endcase
   end

   // flag results shared by all three shifts
   always_comb begin
      z_out = (result == 8'h00);
      n_out = result[7];
      v_out = result[7] ^ c_out;
   end
endmodule
`default_nettype wire

// [logic/cpu_bit_flag_transfer_exec.sv]
// execution of shift, bit, flag and data transfer instructions
// assumes one instruction offered at a time, a data memory with combinational
// read of mem_q.addr while mem_q.re is high, and a write on the edge after we
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
// Function
// - rotate left through carry, flags, one cycle
// - rotate right through carry, flags, one cycle
// - copy register bit b into T only
// - write T into register bit b
// - set or clear V alone, one cycle
// - set or clear H alone, one cycle
// - set or clear S alone, one cycle
// - set or clear N or Z alone
// - load through pointer then increment it, two cycles
// - decrement pointer then load, two cycles
// - load from Y or Z plus q
// - load from absolute address k, two cycles
// - store through pointer then increment, two cycles
// - decrement pointer then store, two cycles
// - plain store leaves pointer and flags alone
module cpu_bit_flag_transfer_exec
   import exec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic req_valid,
   input wire exec_pkg::exec_req_t req,
   input wire logic [7:0] mem_rdata,
   input wire logic [4:0] view_sel,
   output logic busy_q,
   output logic done_q,
   output logic [7:0] flags_q,
   output exec_pkg::mem_req_t mem_q,
   output logic [7:0] view_q
);
   typedef enum {st_idle, st_mem} state_t;

   state_t state_q;
   logic [7:0] regs_q [32];
   logic load_q;
   logic [4:0] dest_q;
   logic take;
   logic mem_op;
   logic [15:0] eff_addr;
   logic [15:0] ptr_now;
   logic [7:0] sh_res;
   logic sh_c, sh_z, sh_n, sh_v;

   // register index of a pointer pair
   function automatic logic [4:0] ptr_lo(input ptr_t p);
      ptr_lo = `PTR_BASE + {2'b00, p, 1'b0};
   endfunction

   // 16-bit value held in a pointer pair
   function automatic logic [15:0] ptr_val(input ptr_t p);
      ptr_val = {regs_q[ptr_lo(p) | 5'h01], regs_q[ptr_lo(p)]};
   endfunction

   flag_shift_unit u_shift (
      .op(req.op),
      .operand(regs_q[req.rd]),
      .carry_in(flags_q[`FLAG_C]),
      .result(sh_res),
      .c_out(sh_c),
      .z_out(sh_z),
      .n_out(sh_n),
      .v_out(sh_v)
   );

   // acceptance and memory-operation decode
   always_comb begin
      take = req_valid && (state_q == st_idle);
      ptr_now = ptr_val(req.ptr);
      mem_op = (req.op == op_indirect_load) || (req.op == op_indirect_write) ||
               (req.op == op_direct_load) ||
               ((req.op == op_displaced_load) && (req.ptr != ptr_x));
   end

   // effective data address
   always_comb begin
      eff_addr = ptr_now;
      unique case (req.op)
         op_displaced_load: eff_addr = ptr_now + {10'h000, req.q};
         op_direct_load: eff_addr = req.k;
         op_indirect_load, op_indirect_write: begin
            if (req.mode == mode_pre_dec) begin
               eff_addr = ptr_now - 16'h0001;
            end
         end
         default: begin
         end
      endcase
   end

   // sequencing: one-cycle ops finish at once, memory ops take a second edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= st_idle;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         load_q <= 1'b0;
         dest_q <= 5'h00;
      end else begin
         done_q <= (take && !mem_op) || (state_q == st_mem);
         if (take && mem_op) begin
            state_q <= st_mem;
            busy_q <= 1'b1;
            load_q <= (req.op != op_indirect_write);
            dest_q <= req.rd;
         end else begin
            state_q <= st_idle;
            busy_q <= 1'b0;
            load_q <= 1'b0;
         end
      end
   end

   // memory access issue, held for the second cycle only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mem_q <= {`ADDR_RESET, `REG_RESET, 1'b0, 1'b0};
      end else begin
         mem_q.we <= 1'b0;
         mem_q.re <= 1'b0;
         if (take && mem_op) begin
            mem_q.addr <= eff_addr;
            mem_q.wdata <= regs_q[req.rr];
            mem_q.we <= (req.op == op_indirect_write);
            mem_q.re <= (req.op != op_indirect_write);
         end
      end
   end

   // register file: results, pointer updates, load returns
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 32; i++) begin
            regs_q[i] <= `REG_RESET;
         end
      end else if (take) begin
         unique case (req.op)
            op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right:
               regs_q[req.rd] <= sh_res;
            op_swap: regs_q[req.rd] <= {regs_q[req.rd][3:0], regs_q[req.rd][7:4]};
            op_flag_to_bit_load: regs_q[req.rd][req.bsel] <= flags_q[`FLAG_T];
            op_move: regs_q[req.rd] <= regs_q[req.rr];
            op_word_copy: begin
               regs_q[{req.rd[4:1], 1'b0}] <= regs_q[{req.rr[4:1], 1'b0}];
               regs_q[{req.rd[4:1], 1'b1}] <= regs_q[{req.rr[4:1], 1'b1}];
            end
            op_indirect_load, op_indirect_write: begin
               if (req.mode == mode_post_inc) begin
                  {regs_q[ptr_lo(req.ptr) | 5'h01], regs_q[ptr_lo(req.ptr)]} <= ptr_now + 16'h0001;
               end else if (req.mode == mode_pre_dec) begin
                  {regs_q[ptr_lo(req.ptr) | 5'h01], regs_q[ptr_lo(req.ptr)]} <= eff_addr;
               end
            end
            default: begin
            end
         endcase
      end else if (load_q) begin
         regs_q[dest_q] <= mem_rdata;
      end
   end

   // flag register; transfers leave it alone
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags_q <= `FLAGS_RESET;
      end else if (take) begin
         unique case (req.op)
            op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right: begin
               flags_q[`FLAG_C] <= sh_c;
               flags_q[`FLAG_Z] <= sh_z;
               flags_q[`FLAG_N] <= sh_n;
               flags_q[`FLAG_V] <= sh_v;
            end
            op_flag_set: flags_q[req.bsel] <= 1'b1;
            op_flag_clear: flags_q[req.bsel] <= 1'b0;
            op_bit_to_flag_store: flags_q[`FLAG_T] <= regs_q[req.rr][req.bsel];
            default: begin
            end
         endcase
      end
   end

   // registered view of one register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         view_q <= `REG_RESET;
      end else begin
         view_q <= regs_q[view_sel];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_rol;
      take && req.op == op_rotate_left_carry |=>
         regs_q[$past(req.rd)] == {$past(regs_q[req.rd][6:0]), $past(flags_q[`FLAG_C])} &&
         flags_q[`FLAG_C] == $past(regs_q[req.rd][7]) && done_q;
   endproperty
   a_rol: assert property (p_rol) else $error("rotate left result wrong");

   property p_ror;
      take && req.op == op_rotate_right_carry |=>
         regs_q[$past(req.rd)] == {$past(flags_q[`FLAG_C]), $past(regs_q[req.rd][7:1])} &&
         flags_q[`FLAG_C] == $past(regs_q[req.rd][0]);
   endproperty
   a_ror: assert property (p_ror) else $error("rotate right result wrong");

   property p_bst;
      take && req.op == op_bit_to_flag_store |=>
         flags_q[`FLAG_T] == $past(regs_q[req.rr][req.bsel]) &&
         flags_q[5:0] == $past(flags_q[5:0]) && flags_q[7] == $past(flags_q[7]);
   endproperty
   a_bst: assert property (p_bst) else $error("bit store to T wrong");

   property p_bld;
      take && req.op == op_flag_to_bit_load |=>
         regs_q[$past(req.rd)][$past(req.bsel)] == $past(flags_q[`FLAG_T]) && $stable(flags_q);
   endproperty
   a_bld: assert property (p_bld) else $error("T to bit load wrong");

   property p_flag_single;
      take && (req.op == op_flag_set || req.op == op_flag_clear) |=>
         (flags_q ^ $past(flags_q)) == ($past(flags_q) ^ ($past(flags_q) & ~(8'h01 << $past(req.bsel)) |
         ({7'h00, $past(req.op) == op_flag_set} << $past(req.bsel)))) && done_q;
   endproperty
   a_flag_single: assert property (p_flag_single) else $error("flag set or clear wrong");

   property p_ld_post_inc;
      take && req.op == op_indirect_load && req.mode == mode_post_inc && req.ptr == ptr_x |=>
         mem_q.re && mem_q.addr == $past(ptr_now) && busy_q && !done_q &&
         {regs_q[27], regs_q[26]} == $past(ptr_now) + 16'h0001 ##1 done_q && !busy_q;
   endproperty
   a_ld_post_inc: assert property (p_ld_post_inc) else $error("post-increment load wrong");

   property p_ld_pre_dec;
      take && req.op == op_indirect_load && req.mode == mode_pre_dec |=>
         mem_q.re && mem_q.addr == $past(ptr_now) - 16'h0001;
   endproperty
   a_ld_pre_dec: assert property (p_ld_pre_dec) else $error("pre-decrement load wrong");

   property p_ldd;
      take && req.op == op_displaced_load && req.ptr == ptr_y |=>
         mem_q.addr == $past(ptr_now) + {10'h000, $past(req.q)} &&
         {regs_q[29], regs_q[28]} == $past(ptr_now) ##1 regs_q[$past(req.rd, 2)] == $past(mem_rdata) &&
         $stable(flags_q);
   endproperty
   a_ldd: assert property (p_ldd) else $error("displaced load wrong");

   property p_lds;
      take && req.op == op_direct_load |=> mem_q.addr == $past(req.k) && mem_q.re ##1 done_q;
   endproperty
   a_lds: assert property (p_lds) else $error("direct load wrong");

   property p_st_pre_dec;
      take && req.op == op_indirect_write && req.mode == mode_pre_dec |=>
         mem_q.we && !mem_q.re && mem_q.addr == $past(ptr_now) - 16'h0001 &&
         mem_q.wdata == $past(regs_q[req.rr]) ##1 !mem_q.we && done_q;
   endproperty
   a_st_pre_dec: assert property (p_st_pre_dec) else $error("pre-decrement store wrong");

   property p_asr;
      take && req.op == op_arith_shift_right |=>
         regs_q[$past(req.rd)] == {$past(regs_q[req.rd][7]), $past(regs_q[req.rd][7:1])};
   endproperty
   a_asr: assert property (p_asr) else $error("arithmetic shift wrong");

   property p_swap;
      take && req.op == op_swap |=>
         regs_q[$past(req.rd)] == {$past(regs_q[req.rd][3:0]), $past(regs_q[req.rd][7:4])} &&
         $stable(flags_q);
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong");

   property p_ldd_x;
      take && req.op == op_displaced_load && req.ptr == ptr_x |=> !mem_q.re && !busy_q && done_q;
   endproperty
   a_ldd_x: assert property (p_ldd_x) else $error("displaced load via first pair not refused");

   property p_st_post_inc;
      take && req.op == op_indirect_write && req.mode == mode_post_inc && req.ptr == ptr_z |=>
         mem_q.we && mem_q.addr == $past(ptr_now) && mem_q.wdata == $past(regs_q[req.rr]) &&
         {regs_q[31], regs_q[30]} == $past(ptr_now) + 16'h0001 ##1 done_q && !busy_q;
   endproperty
   a_st_post_inc: assert property (p_st_post_inc) else $error("post-increment store wrong");

   property p_st_plain;
      take && req.op == op_indirect_write && req.mode == mode_plain && req.ptr == ptr_y |=>
         mem_q.we && mem_q.addr == $past(ptr_now) && $stable(flags_q) &&
         {regs_q[29], regs_q[28]} == $past(ptr_now);
   endproperty
   a_st_plain: assert property (p_st_plain) else $error("plain store wrong");

   property p_move;
      take && req.op == op_move |=> regs_q[$past(req.rd)] == $past(regs_q[req.rr]) && done_q;
   endproperty
   a_move: assert property (p_move) else $error("byte copy wrong");

   property p_word_copy;
      take && req.op == op_word_copy |=>
         regs_q[{$past(req.rd[4:1]), 1'b0}] == $past(regs_q[{req.rr[4:1], 1'b0}]) &&
         regs_q[{$past(req.rd[4:1]), 1'b1}] == $past(regs_q[{req.rr[4:1], 1'b1}]) &&
         $stable(flags_q) && done_q;
   endproperty
   a_word_copy: assert property (p_word_copy) else $error("word copy wrong");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the shift, flag and transfer execution block
// assumes exec_pkg compiled first; a small data memory is modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import exec_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   exec_req_t req = '0;
   logic [7:0] mem_rdata;
   logic [4:0] view_sel = 5'h00;
   logic busy_q;
   logic done_q;
   logic [7:0] flags_q;
   logic [7:0] view_q;
   mem_req_t mem_q;
   mem_req_t m1;
   logic busy1;
   logic [7:0] mem [0:255];
   int cyc;
   int miscompares = 0;
   int total_checks = 0;

   cpu_bit_flag_transfer_exec DUT (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
      .mem_rdata(mem_rdata), .view_sel(view_sel), .busy_q(busy_q), .done_q(done_q),
      .flags_q(flags_q), .mem_q(mem_q), .view_q(view_q));

   // clock, then memory: idle read shows inverted data
   always #5 clock = ~clock;
   assign mem_rdata = mem_q.re ? mem[mem_q.addr[7:0]] : ~mem[mem_q.addr[7:0]];
   always @(posedge clock) if (mem_q.we) mem[mem_q.addr[7:0]] <= mem_q.wdata;

   // compare and count
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   // offer one instruction, wait for done, keep first-cycle memory request
   task go(input op_t o, input logic [4:0] d = 5'h00, input logic [4:0] r = 5'h00,
      input logic [2:0] b = 3'h0, input ptr_t p = ptr_x, input mode_t m = mode_plain,
      input logic [5:0] q = 6'h00, input logic [15:0] k = 16'h0000);
      req = {o, d, r, b, p, m, q, k};
      req_valid = 1'b1;
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      busy1 = busy_q;
      m1 = mem_q;
      cyc = 1;
      while (done_q !== 1'b1 && cyc < 8) begin
         @(posedge clock);
         #1;
         cyc++;
      end
      // idle edge so the next offer never lands in this time step
      @(posedge clock);
      #1;
   endtask

   task rchk(input string n, input logic [4:0] r, input logic [7:0] e);
      view_sel = r;
      @(posedge clock);
      #1;
      chk(n, {8'h00, view_q}, {8'h00, e});
   endtask

   task setr(input logic [4:0] r, input logic [7:0] v);
      mem[8'hf0] = v;
      go(op_direct_load, r, 5'h00, 3'h0, ptr_x, mode_plain, 6'h00, 16'h00f0);
   endtask

   task un(input op_t o, input logic [4:0] r, input logic [7:0] ev, input logic [7:0] ef);
      go(o, r);
      chk("cycles", cyc[15:0], 16'h0001);
      chk("flags", {8'h00, flags_q}, {8'h00, ef});
      rchk("result", r, ev);
   endtask

   task t_direct;
      chk("reset flags", {8'h00, flags_q}, 16'h0000);
      setr(5'd16, 8'h81);
      chk("cycles", cyc[15:0], 16'h0002);
      chk("busy", {15'h0, busy1}, 16'h0001);
      chk("addr", m1.addr, 16'h00f0);
      chk("read", {15'h0, m1.re}, 16'h0001);
      rchk("data", 5'd16, 8'h81);
   endtask

   task t_shift;
      un(op_rotate_left_carry, 5'd16, 8'h02, 8'h09);
      un(op_rotate_left_carry, 5'd16, 8'h05, 8'h00);
      un(op_rotate_right_carry, 5'd16, 8'h02, 8'h09);
      un(op_rotate_right_carry, 5'd16, 8'h81, 8'h0c);
      un(op_arith_shift_right, 5'd16, 8'hc0, 8'h05);
      setr(5'd17, 8'h80);
      go(op_flag_clear);
      un(op_rotate_left_carry, 5'd17, 8'h00, 8'h0b);
      un(op_swap, 5'd16, 8'h0c, 8'h0b);
   endtask

   // every flag index set then cleared, back to back
   task t_flags;
      logic [7:0] f;
      f = 8'h0b;
      for (int i = 0; i < 16; i++) begin
         f[i % 8] = (i < 8);
         go((i < 8) ? op_flag_set : op_flag_clear, 5'h00, 5'h00, i[2:0]);
         chk("cycles", cyc[15:0], 16'h0001);
         chk("flag", {8'h00, flags_q}, {8'h00, f});
      end
   endtask

   task t_bit;
      go(op_bit_to_flag_store, 5'h00, 5'd16, 3'd2);
      chk("T", {8'h00, flags_q}, 16'h0040);
      go(op_flag_to_bit_load, 5'd17, 5'h00, 3'd5);
      chk("flags", {8'h00, flags_q}, 16'h0040);
      rchk("bit", 5'd17, 8'h20);
      go(op_bit_to_flag_store, 5'h00, 5'd16, 3'd0);
      chk("T", {8'h00, flags_q}, 16'h0000);
   endtask

   // pointer loads and stores; X starts at 00ff to carry into the high byte
   task t_ptr;
      setr(5'd26, 8'hff);
      setr(5'd28, 8'h10);
      setr(5'd30, 8'h20);
      mem[8'hff] = 8'h3c;
      mem[8'h4f] = 8'ha5;
      go(op_indirect_load, 5'd1, 5'h00, 3'h0, ptr_x, mode_post_inc);
      chk("addr", m1.addr, 16'h00ff);
      chk("cycles", cyc[15:0], 16'h0002);
      rchk("data", 5'd1, 8'h3c);
      rchk("ptr lo", 5'd26, 8'h00);
      rchk("ptr hi", 5'd27, 8'h01);
      go(op_indirect_load, 5'd2, 5'h00, 3'h0, ptr_x, mode_pre_dec);
      chk("addr", m1.addr, 16'h00ff);
      chk("cycles", cyc[15:0], 16'h0002);
      rchk("data", 5'd2, 8'h3c);
      rchk("ptr hi", 5'd27, 8'h00);
      go(op_displaced_load, 5'd3, 5'h00, 3'h0, ptr_y, mode_plain, 6'h3f);
      chk("addr", m1.addr, 16'h004f);
      rchk("data", 5'd3, 8'ha5);
      rchk("ptr", 5'd28, 8'h10);
      go(op_displaced_load, 5'd4, 5'h00, 3'h0, ptr_x, mode_plain, 6'h01);
      chk("no read", {15'h0, m1.re}, 16'h0000);
      rchk("kept", 5'd4, 8'h00);
      go(op_indirect_write, 5'h00, 5'd3, 3'h0, ptr_z, mode_post_inc);
      chk("addr", m1.addr, 16'h0020);
      chk("wdata", {8'h00, m1.wdata}, 16'h00a5);
      chk("cycles", cyc[15:0], 16'h0002);
      chk("stored", {8'h00, mem[8'h20]}, 16'h00a5);
      rchk("ptr", 5'd30, 8'h21);
      go(op_indirect_write, 5'h00, 5'd1, 3'h0, ptr_z, mode_pre_dec);
      chk("addr", m1.addr, 16'h0020);
      chk("stored", {8'h00, mem[8'h20]}, 16'h003c);
      rchk("ptr", 5'd30, 8'h20);
      go(op_indirect_write, 5'h00, 5'd2, 3'h0, ptr_y, mode_plain);
      chk("write", {15'h0, m1.we}, 16'h0001);
      chk("stored", {8'h00, mem[8'h10]}, 16'h003c);
      chk("flags", {8'h00, flags_q}, 16'h0000);
      rchk("ptr", 5'd28, 8'h10);
   endtask

   task t_copy;
      go(op_move, 5'd6, 5'd3);
      chk("cycles", cyc[15:0], 16'h0001);
      rchk("byte", 5'd6, 8'ha5);
      go(op_word_copy, 5'd8, 5'd2);
      chk("cycles", cyc[15:0], 16'h0001);
      chk("flags", {8'h00, flags_q}, 16'h0000);
      rchk("word lo", 5'd8, 8'h3c);
      rchk("word hi", 5'd9, 8'ha5);
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // main sequence
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      repeat (20) @(posedge clock);
      #1;
      rst = 1'b0;
      t_direct;
      t_shift;
      t_flags;
      t_bit;
      t_ptr;
      t_copy;
      stop_test;
   end

   // watchdog
   initial begin
      #100000;
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
